//--- logic/emb_ctrl.sv
`timescale 1ns/1ps
// External memory sequencer: word/byte cycles, wait states, DMA handover
module emb_ctrl
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // Processor access path
  input  wire logic        acc_valid,
  input  wire logic        acc_external,
  input  wire logic        acc_write,
  input  wire logic [1:0]  acc_byte_en,
  input  wire logic [15:0] acc_addr,
  input  wire logic [15:0] acc_wdata,
  output logic             acc_ready,
  output logic [15:0]      acc_rdata,
  // Memory pins
  input  wire logic        byte_access_select,
  input  wire logic        wait_request,
  input  wire logic        dma_request,
  output logic             dma_grant,
  output logic             processor_clock_output,
  output logic             chip_select_n,
  output logic             chip_select_n_oe,
  output logic             lower_write_strobe_n,
  output logic             upper_write_strobe_n,
  output logic             write_strobes_oe,
  output logic [15:0]      address_bus,
  output logic             address_bus_oe,
  input  wire logic [15:0] data_bus_in,
  output logic [15:0]      data_bus_out,
  output logic             low_data_lane_oe,
  output logic             high_data_lane_oe
);

  emb_req_if sreq ();

  emb_sync u_sync
  (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .dma_request  (dma_request),
    .wait_request (wait_request),
    .req          (sreq.source)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Phase codes under local names, so the case items stay short
  typedef emb_pkg::emb_phase_type emb_phase_type;
  localparam emb_phase_type
    EMB_IDLE  = emb_pkg::EMB_IDLE,
    EMB_ADDR  = emb_pkg::EMB_ADDR,
    EMB_SETUP = emb_pkg::EMB_SETUP,
    EMB_WAIT1 = emb_pkg::EMB_WAIT1,
    EMB_WAIT2 = emb_pkg::EMB_WAIT2,
    EMB_XFER  = emb_pkg::EMB_XFER,
    EMB_HOLD  = emb_pkg::EMB_HOLD,
    EMB_DMA   = emb_pkg::EMB_DMA;
  emb_phase_type phase_r;
  logic          bacc_r;      // Latched byte-access select
  logic          second_r;    // In second byte cycle
  logic          write_r;
  logic          ext_r;
  logic [1:0]    be_r;
  logic [15:0]   addr_r;
  logic [15:0]   wdata_r;
  logic          boot_hold_r; // Set by every reset; cleared once acc_valid is low or phase leaves idle
  logic          bsel_s1_r;
  logic          bsel_s2_r;
  logic          bsel_s3_r;
  logic          bsel_q_r;

  // Byte-select pin synchroniser
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bsel_s1_r <= 1'b0;
      bsel_s2_r <= 1'b0;
      bsel_s3_r <= 1'b0;
      bsel_q_r  <= 1'b0;
    end
    else
    begin
      bsel_s1_r <= byte_access_select;
      bsel_s2_r <= bsel_s1_r;
      bsel_s3_r <= bsel_s2_r;
      if (bsel_s2_r == bsel_s3_r)
        bsel_q_r <= bsel_s3_r;
    end
  end

  // Request held through reset: hold off accesses until acc_valid drops or the phase leaves idle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      boot_hold_r <= 1'b1;
    else if (phase_r != EMB_IDLE || !acc_valid)
      boot_hold_r <= 1'b0;                          // RL19
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  // A phase is one sys_clk; two phases form one processor cycle, so the
  // clock output is high in address/wait1/xfer-type first halves.
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      phase_r  <= EMB_IDLE;
      second_r <= 1'b0;
      bacc_r   <= 1'b0;
      write_r  <= 1'b0;
      ext_r    <= 1'b0;
      be_r     <= 2'h0;
      addr_r   <= emb_pkg::EMB_ADDR_RST;
      wdata_r  <= emb_pkg::EMB_DATA_RST;
    end
    else
    begin
      case (phase_r)
        EMB_IDLE:
        begin
          second_r <= 1'b0;
          // Idle: request sampled at every sys_clk edge
          if (sreq.dma_req_s)
            phase_r <= EMB_DMA;                     // RL14 RL19
          else if (acc_valid && !boot_hold_r)
          begin
            write_r <= acc_write;
            ext_r   <= acc_external;
            be_r    <= acc_byte_en;
            addr_r  <= {acc_addr[15:1], 1'b0};      // RL1
            wdata_r <= acc_wdata;
            phase_r <= EMB_ADDR;                    // RL22
          end
        end
        EMB_ADDR:
          phase_r <= EMB_SETUP;
        EMB_SETUP:
        begin
          if (!second_r)
            bacc_r <= bsel_q_r;                     // RL2
          if (ext_r && sreq.wait_s)
            phase_r <= EMB_WAIT1;                   // RL9 RL11
          else
            phase_r <= EMB_XFER;                    // RL12
        end
        EMB_WAIT1:
          phase_r <= EMB_WAIT2;                     // RL9
        EMB_WAIT2:
          phase_r <= sreq.wait_s ? EMB_WAIT1 : EMB_XFER; // RL10
        EMB_XFER:
          phase_r <= EMB_HOLD;
        EMB_HOLD:
        begin
          if (ext_r && bacc_r && !second_r)
          begin
            second_r <= 1'b1;                       // RL3 RL5
            addr_r   <= {addr_r[15:1], 1'b1};       // RL4
            phase_r  <= EMB_ADDR;
          end
          else if (ext_r && sreq.dma_req_s)
            phase_r <= EMB_DMA;                     // RL13 RL17
          else
            phase_r <= EMB_IDLE;
        end
        EMB_DMA:
          if (!sreq.dma_req_s)
            phase_r <= EMB_IDLE;                    // RL16
        default:
          phase_r <= EMB_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers, all registered from next-phase decisions
  // ----------------------------------------------------------------
  emb_phase_type phase_nxt;
  logic          in_cycle_nxt;
  logic          ext_drive_nxt;

  // Mirror of the sequencer choice so pins align with the phase
  always_comb
  begin
    phase_nxt = phase_r;
    case (phase_r)
      EMB_IDLE:  phase_nxt = sreq.dma_req_s ? EMB_DMA :
                             ((acc_valid && !boot_hold_r) ? EMB_ADDR : EMB_IDLE);
      EMB_ADDR:  phase_nxt = EMB_SETUP;
      EMB_SETUP: phase_nxt = (ext_r && sreq.wait_s) ? EMB_WAIT1 : EMB_XFER;
      EMB_WAIT1: phase_nxt = EMB_WAIT2;
      EMB_WAIT2: phase_nxt = sreq.wait_s ? EMB_WAIT1 : EMB_XFER;
      EMB_XFER:  phase_nxt = EMB_HOLD;
      EMB_HOLD:  phase_nxt = (ext_r && bacc_r && !second_r) ? EMB_ADDR :
                             ((ext_r && sreq.dma_req_s) ? EMB_DMA : EMB_IDLE);
      EMB_DMA:   phase_nxt = sreq.dma_req_s ? EMB_DMA : EMB_IDLE;
      default:   phase_nxt = EMB_IDLE;
    endcase
    in_cycle_nxt  = (phase_nxt != EMB_IDLE) && (phase_nxt != EMB_DMA);
    ext_drive_nxt = in_cycle_nxt && (phase_r == EMB_IDLE ? acc_external : ext_r);
  end

  // Clock output: high in first half of each processor cycle
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      processor_clock_output <= 1'b1;
    else if (phase_nxt == EMB_ADDR || phase_nxt == EMB_WAIT1 || phase_nxt == EMB_XFER)
      processor_clock_output <= 1'b1;               // RL22
    else if (phase_nxt == EMB_IDLE || phase_nxt == EMB_DMA)
      processor_clock_output <= ~processor_clock_output;
    else
      processor_clock_output <= 1'b0;
  end

  // Float every bus pin for DMA, before grant rises
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      chip_select_n_oe <= 1'b0;
      write_strobes_oe <= 1'b0;
      address_bus_oe   <= 1'b0;
    end
    else
    begin
      chip_select_n_oe <= (phase_nxt != EMB_DMA);   // RL15
      write_strobes_oe <= (phase_nxt != EMB_DMA);   // RL15
      address_bus_oe   <= (phase_nxt != EMB_DMA);   // RL15
    end
  end

  // Grant one cycle after the pins float; dropped with the pins restored
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      dma_grant <= 1'b0;
    else
      dma_grant <= (phase_r == EMB_DMA) && (phase_nxt == EMB_DMA); // RL15 RL16 RL21
  end

  // Address, chip select and write strobes
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      address_bus          <= emb_pkg::EMB_ADDR_RST;
      chip_select_n        <= 1'b1;
      lower_write_strobe_n <= 1'b1;
      upper_write_strobe_n <= 1'b1;
    end
    else
    begin
      // Internal cycles still show the address
      if (phase_r == EMB_IDLE && phase_nxt == EMB_ADDR)
        address_bus <= {acc_addr[15:1], 1'b0};      // RL24
      else if (phase_r == EMB_HOLD && phase_nxt == EMB_ADDR)
        address_bus <= {addr_r[15:1], 1'b1};        // RL4
      chip_select_n <= !(ext_drive_nxt && phase_nxt != EMB_ADDR); // RL24
      if (ext_r && write_r && (phase_nxt == EMB_XFER || phase_nxt == EMB_WAIT1 ||
          phase_nxt == EMB_WAIT2))
      begin
        if (!second_r)
        begin
          lower_write_strobe_n <= !be_r[0];         // RL23 RL8
          upper_write_strobe_n <= !be_r[1];         // RL23 RL7
        end
        else
        begin
          lower_write_strobe_n <= !be_r[1];         // RL5 RL7 RL8
          upper_write_strobe_n <= !be_r[1];         // RL5
        end
      end
      else
      begin
        lower_write_strobe_n <= emb_pkg::EMB_STROBE_OFF[0];
        upper_write_strobe_n <= emb_pkg::EMB_STROBE_OFF[1];
      end
    end
  end

  // Data lanes: driven from data setup to hold on external writes only
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      data_bus_out      <= emb_pkg::EMB_DATA_RST;
      low_data_lane_oe  <= 1'b0;
      high_data_lane_oe <= 1'b0;
    end
    else
    begin
      if (ext_r && write_r && phase_nxt != EMB_ADDR && in_cycle_nxt)
      begin
        if (!second_r)
        begin
          data_bus_out      <= wdata_r;
          low_data_lane_oe  <= be_r[0];             // RL8
          high_data_lane_oe <= be_r[1] && !bsel_q_r; // RL6
        end
        else
        begin
          data_bus_out      <= {8'h00, wdata_r[15:8]}; // RL5 RL7
          low_data_lane_oe  <= be_r[1];
          high_data_lane_oe <= 1'b0;                // RL6
        end
      end
      else
      begin
        low_data_lane_oe  <= 1'b0;                  // RL24
        high_data_lane_oe <= 1'b0;
      end
    end
  end

  // Read capture at end of transfer; byte mode fills low then high
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      acc_rdata <= emb_pkg::EMB_DATA_RST;
      acc_ready <= 1'b0;
    end
    else
    begin
      acc_ready <= 1'b0;
      if (phase_r == EMB_XFER && !write_r)
      begin
        if (!ext_r || !bacc_r)
          acc_rdata <= data_bus_in;                 // RL3
        else if (!second_r)
          acc_rdata[7:0] <= data_bus_in[7:0];       // RL4
        else
          acc_rdata[15:8] <= data_bus_in[7:0];      // RL5
      end
      if (phase_r == EMB_HOLD && !(ext_r && bacc_r && !second_r))
        acc_ready <= 1'b1;
    end
  end

endmodule : emb_ctrl

//--- logic/emb_pkg.sv
// How it works
// RL1 - Default: 16-bit word access, even address
// RL2 - Latch byte select during data setup
// RL3 - Byte mode splits word into two cycles
// RL4 - Low byte first A0 low, then A0 high
// RL5 - Second cycle: high byte on low lane
// RL6 - Upper lane floats during second cycle
// RL7 - High-byte write: upper strobe, then both
// RL8 - Low-byte write: lower strobe, then none
// RL9 - Wait high adds one wait state
// RL10 - Resample wait in phase two, unlimited
// RL11 - Wait logic holds wait stable
// RL12 - Internal accesses take no wait states
// RL13 - Sample DMA request after select falls
// RL14 - Idle: sample DMA request every rising edge
// RL15 - Float bus before granting DMA
// RL16 - Drop grant on request removal, resume
// RL17 - DMA never breaks external cycle
// RL18 - External pull-ups hold strobes inactive
// RL19 - Request through reset grants before boot
// RL20 - Requester raises request before reset
// RL21 - Grant latency bounded by cycle length
// RL22 - Four half-cycle phases per external cycle
// RL23 - Word write both strobes, byte one
// RL24 - Internal cycle: address out, bus idle
// RL25 - Synchronise DMA request before use
package emb_pkg;

  // ----------------------------------------------------------------
  // Phase encoding (one-hot); each phase is one sys_clk cycle
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    EMB_IDLE  = 8'h01,
    EMB_ADDR  = 8'h02,
    EMB_SETUP = 8'h04,
    EMB_WAIT1 = 8'h08,
    EMB_WAIT2 = 8'h10,
    EMB_XFER  = 8'h20,
    EMB_HOLD  = 8'h40,
    EMB_DMA   = 8'h80
  } emb_phase_type;

  localparam int          EMB_AW         = 16;
  localparam int          EMB_DW         = 16;
  localparam logic [1:0]  EMB_STROBE_OFF = 2'h3;
  localparam logic [15:0] EMB_ADDR_RST   = 16'h0000;
  localparam logic [15:0] EMB_DATA_RST   = 16'h0000;
  localparam int          EMB_SYNC_LEN   = 3;

endpackage : emb_pkg

//--- logic/emb_req_if.sv
`timescale 1ns/1ps
// Synchronised request and wait levels shared with the sequencer
interface emb_req_if;
  logic dma_req_s;
  logic wait_s;
  modport source (output dma_req_s, output wait_s);
  modport sink   (input  dma_req_s, input  wait_s);
endinterface : emb_req_if

//--- logic/emb_sync.sv
`timescale 1ns/1ps
// Three-stage pin synchronisers; a level counts once stages one and two agree
module emb_sync
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic dma_request,
  input  wire logic wait_request,
  emb_req_if.source req
);

  logic [2:0] dma_sh_r;
  logic [2:0] wait_sh_r;
  logic       dma_q_r;
  logic       wait_q_r;

  // ----------------------------------------------------------------
  // Shift chains
  // ----------------------------------------------------------------
  // Stage zero is read only by stage one
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      dma_sh_r  <= 3'h0;
      wait_sh_r <= 3'h0;
    end
    else
    begin
      dma_sh_r  <= {dma_sh_r[1:0], dma_request};   // RL25
      wait_sh_r <= {wait_sh_r[1:0], wait_request};
    end
  end

  // Agreement filter
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      dma_q_r  <= 1'b0;
      wait_q_r <= 1'b0;
    end
    else
    begin
      if (dma_sh_r[2] == dma_sh_r[1])
        dma_q_r <= dma_sh_r[2];                    // RL25
      if (wait_sh_r[2] == wait_sh_r[1])
        wait_q_r <= wait_sh_r[2];
    end
  end

  assign req.dma_req_s = dma_q_r;
  assign req.wait_s    = wait_q_r;

endmodule : emb_sync

//--- test/emb_ctrl_sva.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin protocol checks for the external memory sequencer
// ----------------------------------------------------------------
module emb_ctrl_sva
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        acc_valid,
  input wire logic        acc_external,
  input wire logic        dma_request,
  input wire logic        dma_grant,
  input wire logic        chip_select_n,
  input wire logic        chip_select_n_oe,
  input wire logic        lower_write_strobe_n,
  input wire logic        upper_write_strobe_n,
  input wire logic        write_strobes_oe,
  input wire logic [15:0] address_bus,
  input wire logic        address_bus_oe,
  input wire logic        low_data_lane_oe,
  input wire logic        high_data_lane_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] pend_r;
  // Cycles a held request has gone unanswered; a plain delay range would hide a hang
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      pend_r <= 8'h00;
    else if (dma_request && !dma_grant)
      pend_r <= pend_r + 8'h01;
    else
      pend_r <= 8'h00;
  end
  float_grant_a: assert property (
    dma_grant |-> !(address_bus_oe || chip_select_n_oe || write_strobes_oe
    || low_data_lane_oe || high_data_lane_oe)) else $error("bus driven during grant");
  grant_order_a: assert property (
    $rose(dma_grant) |-> !$past(address_bus_oe) && $past(chip_select_n))
    else $error("grant raised before bus floated");
  grant_drop_a: assert property (
    $fell(dma_request) |-> ##[1:12] !dma_grant) else $error("grant held after removal");
  grant_resume_a: assert property (
    $fell(dma_grant) |-> ##[0:2] address_bus_oe && chip_select_n_oe)
    else $error("bus not resumed after grant");
  grant_bound_a: assert property (pend_r < 8'h28)
    else $error("grant response too slow");
  upper_float_a: assert property (
    chip_select_n_oe && !chip_select_n && address_bus[0] |-> !high_data_lane_oe)
    else $error("upper lane driven in second byte cycle");
  pair_strobe_a: assert property (
    chip_select_n_oe && !chip_select_n && address_bus[0]
    |-> lower_write_strobe_n == upper_write_strobe_n) else $error("second cycle strobes differ");
  strobe_select_a: assert property (
    write_strobes_oe && !(lower_write_strobe_n && upper_write_strobe_n) |-> !chip_select_n)
    else $error("strobe outside select");
  internal_idle_a: assert property (
    acc_valid && !acc_external |-> chip_select_n && lower_write_strobe_n
    && upper_write_strobe_n) else $error("pins active on internal access");
  select_width_a: assert property (
    $fell(chip_select_n) |=> !chip_select_n) else $error("select shorter than two phases");
  select_gap_a: assert property (
    $rose(chip_select_n) |=> chip_select_n || address_bus[0])
    else $error("select gap too short");
  low_lane_a: assert property (
    write_strobes_oe && !chip_select_n && !lower_write_strobe_n |-> low_data_lane_oe)
    else $error("low lane idle during lower strobe");
endmodule : emb_ctrl_sva

bind emb_ctrl emb_ctrl_sva u_sva
(
  .sys_clk(sys_clk), .reset(reset), .acc_valid(acc_valid), .acc_external(acc_external),
  .dma_request(dma_request), .dma_grant(dma_grant), .chip_select_n(chip_select_n),
  .chip_select_n_oe(chip_select_n_oe), .lower_write_strobe_n(lower_write_strobe_n),
  .upper_write_strobe_n(upper_write_strobe_n), .write_strobes_oe(write_strobes_oe),
  .address_bus(address_bus), .address_bus_oe(address_bus_oe),
  .low_data_lane_oe(low_data_lane_oe), .high_data_lane_oe(high_data_lane_oe)
);

//--- test/emb_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: static RAM, wait logic and a DMA requester
// ----------------------------------------------------------------
module emb_mem_model
(
  input  wire logic        sys_clk,
  input  wire logic        byte_mode,
  input  wire logic        wait_hold,
  input  wire logic        dma_want,
  output logic             byte_access_select,
  output logic             wait_request,
  output logic             dma_request,
  input  wire logic        chip_select_n,
  input  wire logic        chip_select_n_oe,
  input  wire logic        lower_write_strobe_n,
  input  wire logic        upper_write_strobe_n,
  input  wire logic        write_strobes_oe,
  input  wire logic [15:0] address_bus,
  input  wire logic [15:0] data_bus_out,
  input  wire logic        low_data_lane_oe,
  input  wire logic        high_data_lane_oe,
  output logic [15:0]      data_bus_in
);
  logic [7:0]  mem [0:255];
  logic [15:0] noise_r;
  logic        hold_r;
  logic        ce_n;
  logic        we0_n;
  logic        we1_n;
  logic [7:0]  a;
  logic [7:0]  lo;
  logic [7:0]  hi;
  // Pull-ups hold select and strobes idle while nobody drives them
  assign ce_n  = chip_select_n_oe ? chip_select_n : 1'b1;
  assign we0_n = write_strobes_oe ? lower_write_strobe_n : 1'b1;
  assign we1_n = write_strobes_oe ? upper_write_strobe_n : 1'b1;
  assign a     = address_bus[7:0];
  assign lo    = low_data_lane_oe ? data_bus_out[7:0] : noise_r[7:0];
  assign hi    = high_data_lane_oe ? data_bus_out[15:8] : noise_r[15:8];
  // Levels come from the bench; byte mode stays steady across an access, wait and DMA request may change mid-access
  assign byte_access_select = byte_mode;
  assign wait_request       = wait_hold;
  assign dma_request        = dma_want;
  initial
  begin
    noise_r = 16'h0000;
    hold_r  = 1'b0;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) ^ 8'h5a;
  end
  // Byte-wide RAM writes on the lower strobe only, as if upper were gated by bit zero
  always @(posedge sys_clk)
  begin
    noise_r <= ~noise_r + 16'h1357;
    hold_r  <= !ce_n;
    if (!ce_n && !byte_mode && !we0_n)
      mem[{a[7:1], 1'b0}] <= lo;
    if (!ce_n && !byte_mode && !we1_n)
      mem[{a[7:1], 1'b1}] <= hi;
    if (!ce_n && byte_mode && !we0_n)
      mem[a] <= lo;
  end
  // Read data lasts one cycle past select; otherwise the lines show noise
  always_comb
  begin
    data_bus_in = noise_r;
    if (!ce_n || hold_r)
    begin
      data_bus_in[7:0] = mem[byte_mode ? a : {a[7:1], 1'b0}];
      if (!byte_mode)
        data_bus_in[15:8] = mem[{a[7:1], 1'b1}];
    end
  end
endmodule : emb_mem_model

//--- test/test_ext_mem_byte_wait_dma.sv
`timescale 1ns/1ps
module test_ext_mem_byte_wait_dma;
  logic        sys_clk, reset, acc_valid, acc_external, acc_write, acc_ready, dma_grant;
  logic [1:0]  acc_byte_en;
  logic [15:0] acc_addr, acc_wdata, acc_rdata, address_bus, data_bus_in, data_bus_out;
  logic        byte_access_select, wait_request, dma_request, processor_clock_output;
  logic        chip_select_n, chip_select_n_oe, lower_write_strobe_n, upper_write_strobe_n;
  logic        write_strobes_oe, address_bus_oe, low_data_lane_oe, high_data_lane_oe;
  logic        byte_mode, wait_hold, dma_want;
  logic [7:0]  ref_mem [0:255];
  int          fail_count, checks_done;
  // ----------------------------------------------------------------
  // Design, far-side model and clock
  // ----------------------------------------------------------------
  emb_ctrl u_dut
  (
    .sys_clk(sys_clk), .reset(reset), .acc_valid(acc_valid), .acc_external(acc_external),
    .acc_write(acc_write), .acc_byte_en(acc_byte_en), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_ready(acc_ready), .acc_rdata(acc_rdata),
    .byte_access_select(byte_access_select), .wait_request(wait_request),
    .dma_request(dma_request), .dma_grant(dma_grant),
    .processor_clock_output(processor_clock_output), .chip_select_n(chip_select_n),
    .chip_select_n_oe(chip_select_n_oe), .lower_write_strobe_n(lower_write_strobe_n),
    .upper_write_strobe_n(upper_write_strobe_n), .write_strobes_oe(write_strobes_oe),
    .address_bus(address_bus), .address_bus_oe(address_bus_oe), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .low_data_lane_oe(low_data_lane_oe),
    .high_data_lane_oe(high_data_lane_oe)
  );
  emb_mem_model u_mem
  (
    .sys_clk(sys_clk), .byte_mode(byte_mode), .wait_hold(wait_hold), .dma_want(dma_want),
    .byte_access_select(byte_access_select), .wait_request(wait_request),
    .dma_request(dma_request), .chip_select_n(chip_select_n),
    .chip_select_n_oe(chip_select_n_oe), .lower_write_strobe_n(lower_write_strobe_n),
    .upper_write_strobe_n(upper_write_strobe_n), .write_strobes_oe(write_strobes_oe),
    .address_bus(address_bus), .data_bus_out(data_bus_out),
    .low_data_lane_oe(low_data_lane_oe), .high_data_lane_oe(high_data_lane_oe),
    .data_bus_in(data_bus_in)
  );
  // Free-running 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want)
    begin
      fail_count++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic test_done;
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // Cycles from request to ready with no wait states
  function automatic int word_lat(input logic bm);
    return bm ? 9 : 5;
  endfunction : word_lat

  // Byte select needs its synchroniser to settle, so it is set well ahead
  task automatic access(input logic ext, wr, bm, input logic [1:0] be,
                        input logic [15:0] ad, wd, input int lo, hi);
    int          n;
    logic [15:0] rd, first_a, last_a;
    logic        seen;
    n = 0;
    seen = 1'b0;
    first_a = ~{ad[15:1], 1'b0};
    last_a = first_a;
    byte_mode = bm;
    repeat (5) @(negedge sys_clk);
    acc_valid = 1'b1;
    acc_external = ext;
    acc_write = wr;
    acc_byte_en = be;
    acc_addr = ad;
    acc_wdata = wd;
    while (acc_ready !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
      if (chip_select_n_oe === 1'b1 && chip_select_n === 1'b0)
      begin
        if (!seen)
          check(16'(processor_clock_output), 16'h0000);
        if (!seen)
          first_a = address_bus;
        seen = 1'b1;
        last_a = address_bus;
      end
    end
    rd = acc_rdata;
    acc_valid = 1'b0;
    check(16'(n >= lo && n <= hi), 16'h0001);
    if (ext)
    begin
      check(first_a, {ad[15:1], 1'b0});
      check(last_a, {ad[15:1], bm});
    end
    if (ext && wr && be[0])
      ref_mem[{ad[7:1], 1'b0}] = wd[7:0];
    if (ext && wr && be[1])
      ref_mem[{ad[7:1], 1'b1}] = wd[15:8];
    if (ext && !wr)
      check(rd, {ref_mem[{ad[7:1], 1'b1}], ref_mem[{ad[7:1], 1'b0}]});
  endtask : access

  // ----------------------------------------------------------------
  // Watchdog: the tests need a few thousand cycles at most
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic        e, w, m;
    logic [1:0]  be;
    logic [15:0] ad;
    fail_count = 0;
    checks_done = 0;
    {reset, acc_valid, acc_external, acc_write, byte_mode, wait_hold, dma_want} = 7'h40;
    {acc_byte_en, acc_addr, acc_wdata} = 34'h0;
    for (int i = 0; i < 256; i++)
      ref_mem[i] = 8'(i) ^ 8'h5a;
    void'($urandom(32'h07ef));
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    // Every strobe pattern in both modes across the top six words, then read back
    for (int k = 0; k < 6; k++)
    begin
      ad = 16'hfffe - 16'(k * 2);
      access(1, 1, k[0], 2'(k / 2 + 1), ad, 16'ha5c3 + 16'(k), word_lat(k[0]), word_lat(k[0]));
      access(1, 0, k[0], 2'h3, ad, 16'h0000, word_lat(k[0]), word_lat(k[0]));
    end
    // Random mix; wait is raised only under internal accesses, which ignore it
    for (int i = 0; i < 40; i++)
    begin
      e = ($urandom % 4) != 0;
      w = $urandom % 2;
      m = $urandom % 2;
      be = w ? 2'($urandom % 3 + 1) : 2'h3;
      ad = 16'($urandom);
      wait_hold = !e && ($urandom % 2);
      access(e, w, m, be, ad, 16'($urandom), word_lat(e && m), word_lat(e && m));
    end
    wait_hold = 1'b0;
    // Wait held far beyond one state keeps the cycle looping through wait1/wait2
    fork
      access(1, 0, 0, 2'h3, ad, 16'h0000, 21, 45);
      begin
        repeat (25) @(negedge sys_clk);
        check(16'(chip_select_n), 16'h0000);
        wait_hold = 1'b0;
      end
      begin
        @(negedge sys_clk);
        wait_hold = 1'b1;
      end
    join
    // Request mid-cycle: the cycle finishes untouched, then the bus is handed over
    fork
      access(1, 1, 0, 2'h3, 16'h0040, 16'h1e2d, 5, 5);
      begin
        repeat (8) @(negedge sys_clk);
        dma_want = 1'b1;
      end
    join
    repeat (12) @(negedge sys_clk);
    check(16'(dma_grant), 16'h0001);
    check(16'(chip_select_n_oe), 16'h0000);
    fork
      access(1, 0, 0, 2'h3, 16'h0040, 16'h0000, 26, 60);
      begin
        repeat (30) @(negedge sys_clk);
        dma_want = 1'b0;
      end
    join
    // Request held through a second reset is granted before any access
    dma_want = 1'b1;
    repeat (2) @(negedge sys_clk);
    reset = 1'b1;
    repeat (20) @(negedge sys_clk);
    reset = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(16'(dma_grant), 16'h0001);
    dma_want = 1'b0;
    repeat (10) @(negedge sys_clk);
    check(16'(dma_grant), 16'h0000);
    access(1, 0, 1, 2'h3, 16'h0040, 16'h0000, 9, 9);
    test_done();
  end
endmodule : test_ext_mem_byte_wait_dma
